// File: rtl/pg4_port.sv
// Four or five pin GPIO port group with APB registers
// Operation
// - Four pins on the small variant, five on the large; unused bits read zero.
// - Every pin does GPIO and can raise its own interrupt.
// - Interrupt flag reads set after its event; write one clears, zero keeps.
// - Mode bit zero is GPIO; one selects peripheral function 0 to 3 by mux.
// - Five-pin: function 0 gives frequency counter pins; function 3 gives LCD segments.
// - Four-pin: upper fields bits 11-8, lower 3-0, input read-only, reset zero.
// - Five-pin: upper fields bits 12-8, lower 4-0, fifth mux 9-8, reset zero.
`timescale 1ns/1ps
module pg4_port #(
   parameter int PIN_COUNT = 5
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic [4:0] pad_in,
   output pg4_pkg::pg4_pad_t pad,
   // Frequency counter channel 1: sense B, sense A, reference, input
   input wire logic [3:0] freq_out,
   input wire logic [3:0] freq_oe,
   output logic [3:0] freq_in,
   // LCD segment drive
   input wire logic [4:0] lcd_seg,
   // Interrupt request
   output logic irq
);
   localparam logic [4:0] PIN_MASK = (PIN_COUNT == 5) ? 5'h1F : 5'h0F;
   localparam logic [9:0] MUX_MASK = (PIN_COUNT == 5) ? 10'h3FF : 10'h0FF;

   logic [4:0] out_value;
   logic [4:0] input_enable_bits;
   logic [4:0] output_enable_bits;
   logic [4:0] pull_direction;
   logic [4:0] pull_enable;
   logic [4:0] irq_flag_bits;
   logic [4:0] edge_select;
   logic [4:0] irq_enable_bits;
   logic [4:0] debounce_enable_bits;
   logic [4:0] peripheral_mode_bits;
   logic [9:0] function_mux_field;
   logic [4:0] sync_a;
   logic [4:0] sync_b;
   logic [4:0] filt;
   logic [4:0] filt_d;
   logic [4:0] in_value;
   logic [4:0] pin_event;
   logic [4:0] wr_bits;
   logic wr;
   logic rd_setup;
   logic hit;
   logic flag_clr_wr;
   logic rd_func;
   logic [31:0] next_rdata;
   pg4_pkg::pg4_pad_t next_pad;
   logic [3:0] next_freq_in;

   // Zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign wr = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign wr_bits = pwdata[pg4_pkg::LOWER_LSB +: 5] & PIN_MASK;
   assign flag_clr_wr = wr & (paddr == pg4_pkg::OFS_IRQF);

   always_comb begin
      case (paddr)
         pg4_pkg::OFS_DATA, pg4_pkg::OFS_IOEN, pg4_pkg::OFS_PULL, pg4_pkg::OFS_IRQF,
         pg4_pkg::OFS_IRQC, pg4_pkg::OFS_DEB, pg4_pkg::OFS_MODE, pg4_pkg::OFS_FUNC: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~hit;

   // Writable fields; unused pins never store a one
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         out_value <= pg4_pkg::PINS_RST;
         input_enable_bits <= pg4_pkg::PINS_RST;
         output_enable_bits <= pg4_pkg::PINS_RST;
         pull_direction <= pg4_pkg::PINS_RST;
         pull_enable <= pg4_pkg::PINS_RST;
         edge_select <= pg4_pkg::PINS_RST;
         irq_enable_bits <= pg4_pkg::PINS_RST;
         debounce_enable_bits <= pg4_pkg::PINS_RST;
         peripheral_mode_bits <= pg4_pkg::PINS_RST;
         function_mux_field <= pg4_pkg::MUX_RST;
      end else if (wr) begin
         case (paddr)
            // Input field is read-only, so only the upper field stores
            pg4_pkg::OFS_DATA: out_value <= pwdata[pg4_pkg::UPPER_LSB +: 5] & PIN_MASK;
            pg4_pkg::OFS_IOEN: begin
               input_enable_bits <= pwdata[pg4_pkg::UPPER_LSB +: 5] & PIN_MASK;
               output_enable_bits <= wr_bits;
            end
            pg4_pkg::OFS_PULL: begin
               pull_direction <= pwdata[pg4_pkg::UPPER_LSB +: 5] & PIN_MASK;
               pull_enable <= wr_bits;
            end
            pg4_pkg::OFS_IRQC: begin
               edge_select <= pwdata[pg4_pkg::UPPER_LSB +: 5] & PIN_MASK;
               irq_enable_bits <= wr_bits;
            end
            pg4_pkg::OFS_DEB: debounce_enable_bits <= wr_bits;
            pg4_pkg::OFS_MODE: peripheral_mode_bits <= wr_bits;
            pg4_pkg::OFS_FUNC: function_mux_field <= pwdata[9:0] & MUX_MASK;
            default: ;
         endcase
      end
   end

   // Read data is captured in the setup cycle so it stands through the access
   always_comb begin
      next_rdata = pg4_pkg::RD_RST;
      case (paddr)
         pg4_pkg::OFS_DATA: begin
            next_rdata[pg4_pkg::UPPER_LSB +: 5] = out_value;
            next_rdata[pg4_pkg::LOWER_LSB +: 5] = in_value;
         end
         pg4_pkg::OFS_IOEN: begin
            next_rdata[pg4_pkg::UPPER_LSB +: 5] = input_enable_bits;
            next_rdata[pg4_pkg::LOWER_LSB +: 5] = output_enable_bits;
         end
         pg4_pkg::OFS_PULL: begin
            next_rdata[pg4_pkg::UPPER_LSB +: 5] = pull_direction;
            next_rdata[pg4_pkg::LOWER_LSB +: 5] = pull_enable;
         end
         pg4_pkg::OFS_IRQF: next_rdata[pg4_pkg::LOWER_LSB +: 5] = irq_flag_bits;
         pg4_pkg::OFS_IRQC: begin
            next_rdata[pg4_pkg::UPPER_LSB +: 5] = edge_select;
            next_rdata[pg4_pkg::LOWER_LSB +: 5] = irq_enable_bits;
         end
         pg4_pkg::OFS_DEB: next_rdata[pg4_pkg::LOWER_LSB +: 5] = debounce_enable_bits;
         pg4_pkg::OFS_MODE: next_rdata[pg4_pkg::LOWER_LSB +: 5] = peripheral_mode_bits;
         pg4_pkg::OFS_FUNC: next_rdata[9:0] = function_mux_field;
         default: ;
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         prdata <= pg4_pkg::RD_RST;
         rd_func <= 1'b0;
      end else if (rd_setup) begin
         prdata <= next_rdata;
         // Mux reads fill bits 9-0, so the pin mask does not apply to them
         rd_func <= (paddr == pg4_pkg::OFS_FUNC);
      end
   end

   // Two-flop synchroniser on the pins
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sync_a <= pg4_pkg::PINS_RST;
         sync_b <= pg4_pkg::PINS_RST;
         filt_d <= pg4_pkg::PINS_RST;
      end else begin
         sync_a <= pad_in;
         sync_b <= sync_a;
         filt_d <= filt;
      end
   end

   // Input reads zero while its input enable is off
   assign in_value = filt & input_enable_bits & PIN_MASK;

   genvar i;
   generate
      for (i = 0; i < pg4_pkg::MAX_PINS; i++) begin : g_pin
         logic [3:0] deb_cnt;
         logic rise;
         logic fall;

         // Filter trades latency for immunity: a change must persist
         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               deb_cnt <= pg4_pkg::DEB_ZERO;
               filt[i] <= 1'b0;
            end else if (!debounce_enable_bits[i] || sync_b[i] == filt[i]) begin
               deb_cnt <= pg4_pkg::DEB_ZERO;
               filt[i] <= debounce_enable_bits[i] ? filt[i] : sync_b[i];
            end else if (deb_cnt == pg4_pkg::DEB_LAST) begin
               deb_cnt <= pg4_pkg::DEB_ZERO;
               filt[i] <= sync_b[i];
            end else begin
               deb_cnt <= deb_cnt + pg4_pkg::DEB_ONE;
            end
         end

         assign rise = filt[i] & ~filt_d[i];
         assign fall = ~filt[i] & filt_d[i];
         // Edge select one means falling edge
         assign pin_event[i] = PIN_MASK[i] & input_enable_bits[i] & ~peripheral_mode_bits[i] &
                               (edge_select[i] ? fall : rise);

         // An event in the clearing cycle wins over the clear
         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               irq_flag_bits[i] <= 1'b0;
            end else if (pin_event[i]) begin
               irq_flag_bits[i] <= 1'b1;
            end else if (flag_clr_wr && wr_bits[i]) begin
               irq_flag_bits[i] <= 1'b0;
            end
         end

         always_comb begin
            next_pad.out[i] = 1'b0;
            next_pad.oe_n[i] = 1'b1;
            next_pad.pull_up[i] = 1'b0;
            next_pad.pull_down[i] = 1'b0;
            if (!PIN_MASK[i]) begin
               next_pad.oe_n[i] = 1'b1;
            end else if (!peripheral_mode_bits[i]) begin
               next_pad.out[i] = out_value[i];
               next_pad.oe_n[i] = ~output_enable_bits[i];
               next_pad.pull_up[i] = pull_enable[i] & pull_direction[i] &
                                     ~output_enable_bits[i];
               next_pad.pull_down[i] = pull_enable[i] & ~pull_direction[i] &
                                       ~output_enable_bits[i];
            end else begin
               case (function_mux_field[i*pg4_pkg::MUX_W +: pg4_pkg::MUX_W])
                  pg4_pkg::FUNC_FREQ: begin
                     if (PIN_COUNT == 5 && i < pg4_pkg::FREQ_PINS) begin
                        next_pad.out[i] = freq_out[i % pg4_pkg::FREQ_PINS];
                        next_pad.oe_n[i] = ~freq_oe[i % pg4_pkg::FREQ_PINS];
                     end
                  end
                  pg4_pkg::FUNC_LCD: begin
                     next_pad.out[i] = lcd_seg[i];
                     next_pad.oe_n[i] = 1'b0;
                  end
                  default: begin
                     // Functions 1 and 2 have nothing here; the pin floats
                     next_pad.oe_n[i] = 1'b1;
                  end
               endcase
            end
         end
      end

      for (i = 0; i < pg4_pkg::FREQ_PINS; i++) begin : g_freq
         assign next_freq_in[i] = (PIN_COUNT == 5) & peripheral_mode_bits[i] &
            (function_mux_field[i*pg4_pkg::MUX_W +: pg4_pkg::MUX_W] == pg4_pkg::FUNC_FREQ) &
            sync_b[i];
      end
   endgenerate

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pad <= '{out: 5'h00, oe_n: 5'h1F, pull_up: 5'h00, pull_down: 5'h00};
         freq_in <= 4'h0;
      end else begin
         pad <= next_pad;
         freq_in <= next_freq_in;
      end
   end

   // Request only for flags whose interrupt enable is set
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_flag_bits & irq_enable_bits);
      end
   end

   // Checks
   property p_flag_set;
      @(posedge clk_sys) disable iff (reset)
      pin_event != 5'h00 |=> (irq_flag_bits & $past(pin_event)) == $past(pin_event);
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("event did not set flag");
   property p_w1c;
      @(posedge clk_sys) disable iff (reset)
      flag_clr_wr && pin_event == 5'h00 |=> (irq_flag_bits & $past(wr_bits)) == 5'h00 &&
         (irq_flag_bits & ~$past(wr_bits)) == ($past(irq_flag_bits) & ~$past(wr_bits));
   endproperty
   a_w1c: assert property (p_w1c) else $error("write one to clear misbehaved");
   property p_unused_zero;
      @(posedge clk_sys) disable iff (reset)
      (prdata[pg4_pkg::UPPER_LSB +: 5] & ~PIN_MASK) == 5'h00 && prdata[31:13] == 19'h0 &&
      (rd_func || (prdata[pg4_pkg::LOWER_LSB +: 5] & ~PIN_MASK) == 5'h00);
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bits read one");
   property p_irq_req;
      @(posedge clk_sys) disable iff (reset)
      (irq_flag_bits & irq_enable_bits) == 5'h00 ##1 (irq_flag_bits & irq_enable_bits) != 5'h00
      |=> irq;
   endproperty
   a_irq_req: assert property (p_irq_req) else $error("irq not raised");
   property p_no_req;
      @(posedge clk_sys) disable iff (reset)
      irq_enable_bits == 5'h00 [*2] |-> !irq;
   endproperty
   a_no_req: assert property (p_no_req) else $error("irq with all enables off");
   property p_gpio_drive;
      @(posedge clk_sys) disable iff (reset)
      !peripheral_mode_bits[0] && output_enable_bits[0] |=> !pad.oe_n[0] &&
         pad.out[0] == $past(out_value[0]);
   endproperty
   a_gpio_drive: assert property (p_gpio_drive) else $error("gpio pin not driven");
   property p_lcd;
      @(posedge clk_sys) disable iff (reset)
      peripheral_mode_bits[1] && function_mux_field[3:2] == pg4_pkg::FUNC_LCD |=>
         !pad.oe_n[1] && pad.out[1] == $past(lcd_seg[1]);
   endproperty
   a_lcd: assert property (p_lcd) else $error("lcd segment not routed");
   property p_input_ro;
      @(posedge clk_sys) disable iff (reset)
      wr && paddr == pg4_pkg::OFS_DATA |=> (in_value == $past(in_value) || filt != $past(filt)) &&
         out_value == ($past(pwdata[12:8]) & PIN_MASK);
   endproperty
   a_input_ro: assert property (p_input_ro) else $error("data register write wrong");
   property p_rd_flags;
      @(posedge clk_sys) disable iff (reset)
      rd_setup && paddr == pg4_pkg::OFS_IRQF |=> prdata[4:0] == $past(irq_flag_bits);
   endproperty
   a_rd_flags: assert property (p_rd_flags) else $error("flag read wrong");

   c_flag: cover property (@(posedge clk_sys) disable iff (reset) pin_event != 5'h00);
   c_clear: cover property (@(posedge clk_sys) disable iff (reset)
      flag_clr_wr && irq_flag_bits != 5'h00);
   c_irq: cover property (@(posedge clk_sys) disable iff (reset) $rose(irq));
   c_race: cover property (@(posedge clk_sys) disable iff (reset)
      flag_clr_wr && (pin_event & wr_bits) != 5'h00);
endmodule

// File: rtl/pg4_pkg.sv
// Constants and types shared by the port group
package pg4_pkg;
   localparam int MAX_PINS = 5;
   localparam int MUX_W = 2;
   localparam int ADDR_W = 12;
   // Register byte addresses
   localparam logic [11:0] OFS_DATA = 12'h000;
   localparam logic [11:0] OFS_IOEN = 12'h004;
   localparam logic [11:0] OFS_PULL = 12'h008;
   localparam logic [11:0] OFS_IRQF = 12'h00C;
   localparam logic [11:0] OFS_IRQC = 12'h010;
   localparam logic [11:0] OFS_DEB = 12'h014;
   localparam logic [11:0] OFS_MODE = 12'h018;
   localparam logic [11:0] OFS_FUNC = 12'h01C;
   // Field positions
   localparam int UPPER_LSB = 8;
   localparam int LOWER_LSB = 0;
   localparam logic [4:0] PINS_RST = 5'h00;
   localparam logic [9:0] MUX_RST = 10'h000;
   localparam logic [31:0] RD_RST = 32'h0000_0000;
   // Function numbers
   localparam logic [1:0] FUNC_FREQ = 2'h0;
   localparam logic [1:0] FUNC_LCD = 2'h3;
   localparam int FREQ_PINS = 4;
   // Chattering filter: input must hold this long before it is accepted
   localparam int CLK_NS = 10;
   localparam int DEB_TIME_NS = 80;
   localparam int DEB_CYCLES = (DEB_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] DEB_LAST = 4'(DEB_CYCLES - 1);
   localparam logic [3:0] DEB_ZERO = 4'h0;
   localparam logic [3:0] DEB_ONE = 4'h1;
   typedef struct packed {
      logic [4:0] out;
      logic [4:0] oe_n;
      logic [4:0] pull_up;
      logic [4:0] pull_down;
   } pg4_pad_t;
endpackage

// File: sim/pg4_pins.sv
// Pin-side model: the level that the port's input buffers see
`timescale 1ns/1ps
module pg4_pins (
   // Clock
   input wire logic clk_sys,
   // Port side
   input wire pg4_pkg::pg4_pad_t pad,
   // Outside drivers
   input wire logic [4:0] ext_val,
   input wire logic [4:0] ext_drv,
   // Level at the pins
   output logic [4:0] pad_in
);
   logic [4:0] float_lvl = 5'h0A;
   // A floating pin must not look stable, so it flips every cycle
   always @(posedge clk_sys) begin
      float_lvl <= ~float_lvl;
   end
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         if (!pad.oe_n[i]) pad_in[i] = pad.out[i];
         else if (ext_drv[i]) pad_in[i] = ext_val[i];
         else if (pad.pull_up[i]) pad_in[i] = 1'b1;
         else if (pad.pull_down[i]) pad_in[i] = 1'b0;
         else pad_in[i] = float_lvl[i];
      end
   end
endmodule

// File: sim/tb.sv
// Self-checking bench for the port group
`timescale 1ns/1ps
module tb;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, w;
   logic [31:0] seed = 32'h0001_32D2;
   logic pready, pslverr, irq;
   logic [4:0] pad_in, ext_val = 5'h00, ext_drv = 5'h1F, lcd_seg = 5'h00;
   logic [3:0] freq_out = 4'h0, freq_oe = 4'h0, freq_in;
   pg4_pkg::pg4_pad_t pad;
   int bad_count = 0, samples_checked = 0;
   // Writable bits per register index, data register out field only
   logic [31:0] msk [8] = '{32'h1F00, 32'h1F1F, 32'h1F1F, 32'h001F,
                            32'h1F1F, 32'h001F, 32'h001F, 32'h03FF};
   always #5 clk_sys = ~clk_sys;
   pg4_port #(.PIN_COUNT(5)) u_dut (.clk_sys(clk_sys), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
      .pad(pad), .freq_out(freq_out), .freq_oe(freq_oe), .freq_in(freq_in),
      .lcd_seg(lcd_seg), .irq(irq));
   pg4_pins u_pins (.clk_sys(clk_sys), .pad(pad), .ext_val(ext_val),
      .ext_drv(ext_drv), .pad_in(pad_in));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic print_verdict();
      if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", what, e, g);
         bad_count++;
      end
   endtask
   // One APB transfer; idx is the register index, byte address four times it
   task automatic apb(input logic wr, input int idx, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= 12'(4 * idx);
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         n++;
      end
      if (n == 20) begin
         bad_count++;
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rchk(input string what, input int idx, input logic [31:0] e);
      apb(1'b0, idx, 32'h0);
      chk(what, e, rd);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   initial begin
      tick(2);
      reset <= 1'b0;
      tick(1);
      for (int i = 0; i < 8; i++) rchk("reset value", i, 32'h0);
      chk("oe_n after reset", 32'h1F, 32'(pad.oe_n));
      repeat (3) for (int i = 1; i < 8; i++) begin
         if (i != 3) begin
            w = rnd();
            apb(1'b1, i, w);
            rchk("read back", i, w & msk[i]);
         end
      end
      apb(1'b1, 8, 32'hFFFF);
      chk("slverr", 32'h1, 32'(err));
      rchk("unmapped", 8, 32'h0);
      chk("slverr read", 32'h1, 32'(err));
      // GPIO output drive, written input bits must not stick
      // Leftover random filter enables would delay every pin edge below
      apb(1'b1, 5, 32'h0);
      apb(1'b1, 6, 32'h0);
      apb(1'b1, 1, 32'h001F);
      w = rnd();
      apb(1'b1, 0, w);
      // Pad registers load on the edge the task returns at; look one edge later
      tick(1);
      chk("pad out", 32'(w[12:8]), 32'(pad.out));
      chk("pad oe_n", 32'h0, 32'(pad.oe_n));
      rchk("data reg", 0, w & 32'h1F00);
      // Pulls reach the floating pins and the input field
      apb(1'b1, 1, 32'h1F00);
      apb(1'b1, 2, 32'h0A1F);
      ext_drv <= 5'h00;
      tick(6);
      chk("pull up", 32'h0A, 32'(pad.pull_up));
      chk("pull down", 32'h15, 32'(pad.pull_down));
      rchk("in via pull", 0, (w & 32'h1F00) | 32'h0A);
      ext_drv <= 5'h1F;
      apb(1'b1, 2, 32'h0);
      // Rising edges, enable only pins 0, 2 and 4
      apb(1'b1, 4, 32'h0015);
      apb(1'b1, 3, 32'h1F);
      rchk("flags clear", 3, 32'h0);
      chk("irq idle", 32'h0, 32'(irq));
      ext_val <= 5'h1F;
      tick(10);
      rchk("rise flags", 3, 32'h1F);
      chk("irq set", 32'h1, 32'(irq));
      rchk("in field", 0, (w & 32'h1F00) | 32'h1F);
      apb(1'b1, 3, 32'h0);
      rchk("w0 keeps", 3, 32'h1F);
      apb(1'b1, 3, 32'h15);
      rchk("w1 clears", 3, 32'h0A);
      chk("irq masked", 32'h0, 32'(irq));
      // Falling edges on every pin
      apb(1'b1, 4, 32'h1F1F);
      apb(1'b1, 3, 32'h1F);
      ext_val <= 5'h00;
      tick(10);
      rchk("fall flags", 3, 32'h1F);
      chk("irq fall", 32'h1, 32'(irq));
      // Debounce: a short glitch is dropped, a held level is taken
      apb(1'b1, 5, 32'h1F);
      apb(1'b1, 4, 32'h001F);
      apb(1'b1, 3, 32'h1F);
      ext_val <= 5'h01;
      tick(3);
      ext_val <= 5'h00;
      tick(20);
      rchk("glitch", 3, 32'h0);
      ext_val <= 5'h01;
      tick(20);
      rchk("held", 3, 32'h01);
      // Peripheral modes
      apb(1'b1, 5, 32'h0);
      apb(1'b1, 1, 32'h0);
      apb(1'b1, 6, 32'h1F);
      apb(1'b1, 7, 32'h3FF);
      for (int k = 0; k < 4; k++) begin
         lcd_seg <= 5'(rnd());
         tick(3);
         chk("lcd out", 32'(lcd_seg), 32'(pad.out));
         chk("lcd oe_n", 32'h0, 32'(pad.oe_n));
      end
      apb(1'b1, 7, 32'h300);
      freq_oe <= 4'h5;
      freq_out <= 4'(rnd());
      ext_val <= 5'h0A;
      tick(6);
      chk("freq oe_n", 32'h0A, 32'(pad.oe_n[3:0]));
      chk("freq out", 32'(freq_out & 4'h5), 32'(pad.out[3:0] & 4'h5));
      chk("freq in", 32'((freq_out & 4'h5) | 4'hA), 32'(freq_in));
      apb(1'b1, 7, 32'h155);
      apb(1'b1, 1, 32'h1F00);
      apb(1'b1, 3, 32'h1F);
      tick(3);
      chk("func1 oe_n", 32'h1F, 32'(pad.oe_n));
      chk("func1 freq", 32'h0, 32'(freq_in));
      ext_val <= 5'h15;
      tick(10);
      rchk("mode blocks", 3, 32'h0);
      print_verdict();
   end
endmodule
